// ==== include/slpm_map.svh ====
`ifndef SLPM_MAP_SVH
`define SLPM_MAP_SVH

// lamp and pattern counts
`define SLPM_N_STATUS 7
`define SLPM_N_INPUT 16
`define SLPM_N_PAT 29

// pattern codes; codes 0 to 15 are input-state patterns 1 to 16
`define SLPM_PAT_INPUT_1 5'h00
`define SLPM_PAT_AIR_OFF 5'h10
`define SLPM_PAT_AIR_DONE 5'h11
`define SLPM_PAT_HI_TEMP 5'h12
`define SLPM_PAT_PURGING 5'h13
`define SLPM_PAT_PURGE_DONE 5'h14
`define SLPM_PAT_POSTPURGE 5'h15
`define SLPM_PAT_BLOWER 5'h16
`define SLPM_PAT_HIGH_FIRE 5'h17
`define SLPM_PAT_MODULATING 5'h18
`define SLPM_PAT_RELAY 5'h19
`define SLPM_PAT_UPSTREAM 5'h1a
`define SLPM_PAT_ZONE 5'h1b
`define SLPM_PAT_UNUSED 5'h1c

// reset values of the configuration
`define SLPM_RST_ST1 `SLPM_PAT_AIR_DONE
`define SLPM_RST_ST2 `SLPM_PAT_PURGING
`define SLPM_RST_ST3 `SLPM_PAT_PURGE_DONE
`define SLPM_RST_ST4 `SLPM_PAT_ZONE
`define SLPM_RST_ST_REST `SLPM_PAT_UNUSED
`define SLPM_RST_USED 16'h0000
`define SLPM_RST_ERR_DETAILED 1'b1
`define SLPM_RST_ZONE_TYPE 1'b0

// flash timing: half period in ms, clock in kHz
`define SLPM_FLASH_HALF_MS 500
`define SLPM_CLK_KHZ 50000
`define SLPM_FLASH_HALF_CYC (`SLPM_FLASH_HALF_MS * `SLPM_CLK_KHZ)

`endif

// ==== include/slpm_pkg.sv ====
package slpm_pkg;

    typedef logic [4:0] slpm_pat_t;

    typedef struct packed {
        logic air_switch_off_confirmed;
        logic air_switch_check_done;
        logic high_temp_mode;
        logic prepurge_running;
        logic postpurge_running;
        logic startup_in;
        logic blower_out;
        logic high_fire_hold;
        logic damper_modulating;
        logic relay_out;
        logic interlock_trip;
        logic interlock_normal;
        logic zone_permitted;
    } slpm_cond_s;

    typedef struct packed {
        slpm_pat_t [6:0] status_sel;
        slpm_pat_t [15:0] input_sel;
        logic [15:0] input_used;
        logic err_detailed;
        logic zone_type;
    } slpm_cfg_s;

endpackage

// ==== core/slpm_top.sv ====
// Operation
// - sixteen input-state patterns, pattern n follows interlock input n
// - input pattern dark when unused; lit when closed or off-delay runs
// - input pattern flashes when used, contact open, no off-delay running
// - air-switch-off pattern lights once switch off is confirmed
// - air-switch-check-done pattern lights when the check completes
// - high-temperature pattern lit while the 760 degree mode runs
// - purging pattern lit during prepurge, dark when it ends
// - purge-done lights at prepurge end, holds until startup drops
// - postpurge pattern lit while postpurge runs
// - blower pattern mirrors the blower output
// - firing-position pattern lit at high fire, dark while modulating
// - modulation pattern lit exactly while damper modulates
// - relay pattern mirrors the relay output
// - upstream pattern: trip dark, normal lit, else flash; zone type only
// - zone-permission pattern lit while zone operations are permitted
// - unused pattern is always dark
// - default lamp assignment: status 1-4 fixed, 5-7 unused, input n
// - a setting selects simple two-digit or detailed four-digit format
// - error format is detailed four-digit after reset
// - each lamp shows the pattern that the loaded configuration assigns
`include "slpm_map.svh"

module slpm_top
    import slpm_pkg::*;
#(
    parameter int unsigned FLASH_HALF_CYC = `SLPM_FLASH_HALF_CYC
) (
    input wire logic clk, // 50 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [15:0] contact_raw, // interlock contacts, 1 = closed
    input wire logic [15:0] off_delay_running, // per-input off-delay
    input wire slpm_cond_s cond, // sequencer conditions
    input wire logic cfg_load, // one-cycle load of cfg
    input wire slpm_cfg_s cfg, // configuration from loader
    output logic [6:0] status_lamp, // status lamps 1 to 7, bit 0 = 1
    output logic [15:0] input_lamp, // input lamps 1 to 16, bit 0 = 1
    output logic err_fmt_detailed, // 1 = four-digit, 0 = two-digit
    output logic flash_phase // common blink phase
);

    // picks one level out of the pattern vector; unknown codes show dark
    function automatic logic pat_pick(
        input logic [`SLPM_N_PAT-1:0] vec,
        input slpm_pat_t code
    );
        logic r;
        r = 1'b0;
        if (code < 5'(`SLPM_N_PAT)) begin
            r = vec[code];
        end
        return r;
    endfunction

    logic [15:0] contact_meta_reg;
    logic [15:0] contact_reg;
    logic [31:0] flash_cnt_reg;
    logic flash_reg;
    logic prepurge_d_reg;
    logic purge_done_reg;
    logic purge_done_next;
    slpm_pat_t [6:0] status_sel_reg;
    slpm_pat_t [15:0] input_sel_reg;
    logic [15:0] input_used_reg;
    logic err_detailed_reg;
    logic zone_type_reg;
    logic [15:0] input_state_pattern;
    logic upstream_permission_pattern;
    logic [`SLPM_N_PAT-1:0] pat_vec;
    logic [6:0] status_next;
    logic [15:0] input_next;

    // contacts come from field wiring, so two flops before any use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            contact_meta_reg <= 16'h0000;
            contact_reg <= 16'h0000;
        end else begin
            contact_meta_reg <= contact_raw;
            contact_reg <= contact_meta_reg;
        end
    end

    // one prescaler for every flashing lamp keeps them in phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt_reg <= 32'h0000_0000;
            flash_reg <= 1'b0;
        end else if (flash_cnt_reg >= FLASH_HALF_CYC - 1) begin
            flash_cnt_reg <= 32'h0000_0000;
            flash_reg <= ~flash_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
        end
    end

    // purge done: set at the falling edge of prepurge, cleared by startup
    // going low; a set in the same cycle as the clear wins
    always_comb begin
        purge_done_next = purge_done_reg;
        if (!cond.startup_in) begin
            purge_done_next = 1'b0;
        end
        if (prepurge_d_reg && !cond.prepurge_running) begin
            purge_done_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prepurge_d_reg <= 1'b0;
            purge_done_reg <= 1'b0;
        end else begin
            prepurge_d_reg <= cond.prepurge_running;
            purge_done_reg <= purge_done_next;
        end
    end

    // configuration store, loaded whole on one strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_sel_reg[0] <= `SLPM_RST_ST1;
            status_sel_reg[1] <= `SLPM_RST_ST2;
            status_sel_reg[2] <= `SLPM_RST_ST3;
            status_sel_reg[3] <= `SLPM_RST_ST4;
            for (int i = 4; i < `SLPM_N_STATUS; i++) begin
                status_sel_reg[i] <= `SLPM_RST_ST_REST;
            end
            for (int i = 0; i < `SLPM_N_INPUT; i++) begin
                input_sel_reg[i] <= `SLPM_PAT_INPUT_1 + 5'(i);
            end
            input_used_reg <= `SLPM_RST_USED;
            err_detailed_reg <= `SLPM_RST_ERR_DETAILED;
            zone_type_reg <= `SLPM_RST_ZONE_TYPE;
        end else if (cfg_load) begin
            status_sel_reg <= cfg.status_sel;
            input_sel_reg <= cfg.input_sel;
            input_used_reg <= cfg.input_used;
            err_detailed_reg <= cfg.err_detailed;
            zone_type_reg <= cfg.zone_type;
        end
    end

    // input-state patterns; the off-delay keeps an opened contact lit
    always_comb begin
        for (int i = 0; i < `SLPM_N_INPUT; i++) begin
            if (!input_used_reg[i]) begin
                input_state_pattern[i] = 1'b0;
            end else if (contact_reg[i] || off_delay_running[i]) begin
                input_state_pattern[i] = 1'b1;
            end else begin
                input_state_pattern[i] = flash_reg;
            end
        end
    end

    // upstream permission only means something on a zone-type module
    always_comb begin
        if (!zone_type_reg || cond.interlock_trip) begin
            upstream_permission_pattern = 1'b0;
        end else if (cond.interlock_normal) begin
            upstream_permission_pattern = 1'b1;
        end else begin
            upstream_permission_pattern = flash_reg;
        end
    end

    always_comb begin
        pat_vec = '0;
        pat_vec[15:0] = input_state_pattern;
        pat_vec[`SLPM_PAT_AIR_OFF] = cond.air_switch_off_confirmed;
        pat_vec[`SLPM_PAT_AIR_DONE] = cond.air_switch_check_done;
        pat_vec[`SLPM_PAT_HI_TEMP] = cond.high_temp_mode;
        pat_vec[`SLPM_PAT_PURGING] = cond.prepurge_running;
        pat_vec[`SLPM_PAT_PURGE_DONE] = purge_done_reg;
        pat_vec[`SLPM_PAT_POSTPURGE] = cond.postpurge_running;
        pat_vec[`SLPM_PAT_BLOWER] = cond.blower_out;
        // modulation overrides high fire so the two never show together
        pat_vec[`SLPM_PAT_HIGH_FIRE] =
            cond.high_fire_hold && !cond.damper_modulating;
        pat_vec[`SLPM_PAT_MODULATING] = cond.damper_modulating;
        pat_vec[`SLPM_PAT_RELAY] = cond.relay_out;
        pat_vec[`SLPM_PAT_UPSTREAM] = upstream_permission_pattern;
        pat_vec[`SLPM_PAT_ZONE] = cond.zone_permitted;
        pat_vec[`SLPM_PAT_UNUSED] = 1'b0;
    end

    always_comb begin
        for (int i = 0; i < `SLPM_N_STATUS; i++) begin
            status_next[i] = pat_pick(pat_vec, status_sel_reg[i]);
        end
        for (int i = 0; i < `SLPM_N_INPUT; i++) begin
            input_next[i] = pat_pick(pat_vec, input_sel_reg[i]);
        end
    end

    // lamps are registered: one cycle of latency, no glitches on the drivers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_lamp <= 7'h00;
            input_lamp <= 16'h0000;
        end else begin
            status_lamp <= status_next;
            input_lamp <= input_next;
        end
    end

    assign err_fmt_detailed = err_detailed_reg;
    assign flash_phase = flash_reg;

endmodule

// ==== tb/slpm_properties.sv ====
module slpm_properties
    import slpm_pkg::*;
#(
    parameter int unsigned FLASH_HALF_CYC = 4
) (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic [15:0] contact_raw, // contacts
    input wire logic [15:0] off_delay_running, // off-delays
    input wire slpm_cond_s cond, // conditions
    input wire logic cfg_load, // load strobe
    input wire slpm_cfg_s cfg, // config
    input wire logic [6:0] status_lamp, // status lamps
    input wire logic [15:0] input_lamp, // input lamps
    input wire logic err_fmt_detailed, // error format
    input wire logic flash_phase // blink phase
);
    timeunit 1ns;
    timeprecision 100ps;
    // dflt: no load since reset, so the default map is known here
    logic dflt;
    logic seen;
    int hold;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dflt <= 1'b1;
            hold <= 0;
            seen <= 1'b0;
        end else begin
            dflt <= dflt & ~cfg_load;
            hold <= $changed(flash_phase) ? 0 : hold + 1;
            seen <= seen | $changed(flash_phase);
        end
    end
    air_done_lamp_a: assert property (dflt |=> status_lamp[0] ==
        $past(cond.air_switch_check_done)) else $error("lamp 1 wrong");
    purging_lamp_a: assert property (dflt |=> status_lamp[1] ==
        $past(cond.prepurge_running)) else $error("lamp 2 wrong");
    spare_dark_a: assert property (dflt |-> status_lamp[6:4] == 3'h0)
        else $error("spare lamp lit");
    purge_set_a: assert property (dflt && !cfg_load &&
        $fell(cond.prepurge_running) |=> ##1 status_lamp[2])
        else $error("purge done not set");
    purge_clear_a: assert property (dflt && !cfg_load &&
        !cond.startup_in && !$fell(cond.prepurge_running)
        |=> ##1 !status_lamp[2]) else $error("purge done not cleared");
    unused_dark_a: assert property (dflt |-> input_lamp == 16'h0000)
        else $error("unused input lit");
    fmt_load_a: assert property (cfg_load |=>
        err_fmt_detailed == $past(cfg.err_detailed)) else $error("format");
    flash_period_a: assert property (seen && $changed(flash_phase)
        |-> hold == FLASH_HALF_CYC - 1) else $error("blink period");
    load_c: cover property (cfg_load);
    purge_end_c: cover property ($fell(cond.prepurge_running));
    blink_c: cover property (seen && $changed(flash_phase));
endmodule
bind slpm_top slpm_properties #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) u_props (
    .clk(clk), .rst_n(rst_n), .contact_raw(contact_raw),
    .off_delay_running(off_delay_running), .cond(cond), .cfg_load(cfg_load),
    .cfg(cfg), .status_lamp(status_lamp), .input_lamp(input_lamp),
    .err_fmt_detailed(err_fmt_detailed), .flash_phase(flash_phase));

// ==== tb/slpm_loader.sv ====
module slpm_loader
    import slpm_pkg::*;
(
    input wire logic clk, // clock
    output logic cfg_load, // load strobe
    output slpm_cfg_s cfg // config image
);
    timeunit 1ns;
    timeprecision 100ps;
    initial cfg_load = 1'b0;
    initial cfg = '0;
    // image is scrambled after the strobe: only the strobe edge counts
    task automatic send(input slpm_cfg_s c);
        @(posedge clk);
        #1 cfg = c;
        cfg_load = 1'b1;
        @(posedge clk);
        #1 cfg_load = 1'b0;
        cfg = ~c;
    endtask
endmodule

// ==== tb/testbench.sv ====
module testbench;
    import slpm_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, cfg_load, err_fmt_detailed, flash_phase, fp, pd;
    logic [15:0] contact_raw, off_delay_running, input_lamp;
    logic [6:0] status_lamp;
    slpm_cond_s cond, c;
    slpm_cfg_s cfg, m, c2;
    int num_errors = 0;
    int checks = 0;
    slpm_top #(.FLASH_HALF_CYC(4)) uut (.clk(clk), .rst_n(rst_n),
        .contact_raw(contact_raw), .off_delay_running(off_delay_running),
        .cond(cond), .cfg_load(cfg_load), .cfg(cfg),
        .status_lamp(status_lamp), .input_lamp(input_lamp),
        .err_fmt_detailed(err_fmt_detailed), .flash_phase(flash_phase));
    slpm_loader loader (.clk(clk), .cfg_load(cfg_load), .cfg(cfg));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // lamps register the phase seen at the edge, one cycle behind it
    always @(posedge clk) fp <= flash_phase;
    function automatic logic pat(input slpm_pat_t k);
        case (k)
            5'h10: return cond.air_switch_off_confirmed;
            5'h11: return cond.air_switch_check_done;
            5'h12: return cond.high_temp_mode;
            5'h13: return cond.prepurge_running;
            5'h14: return pd;
            5'h15: return cond.postpurge_running;
            5'h16: return cond.blower_out;
            5'h17: return cond.high_fire_hold & ~cond.damper_modulating;
            5'h18: return cond.damper_modulating;
            5'h19: return cond.relay_out;
            5'h1a: return m.zone_type & ~cond.interlock_trip &
                (cond.interlock_normal | fp);
            5'h1b: return cond.zone_permitted;
            default: return k < 5'h10 && m.input_used[k[3:0]] &&
                (contact_raw[k[3:0]] | off_delay_running[k[3:0]] | fp);
        endcase
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input slpm_cond_s n);
        logic [6:0] st;
        logic [15:0] il;
        @(posedge clk);
        #1 pd = n.startup_in && (pd || (cond.prepurge_running &&
            !n.prepurge_running));
        cond = n;
        contact_raw = 16'($urandom);
        off_delay_running = 16'($urandom);
        // three edges of contact latency, one spare
        repeat (4) @(posedge clk);
        #1;
        for (int i = 0; i < 7; i++) st[i] = pat(m.status_sel[i]);
        for (int i = 0; i < 16; i++) il[i] = pat(m.input_sel[i]);
        chk("status_lamp", 16'(status_lamp), 16'(st));
        chk("input_lamp", input_lamp, il);
        chk("err_fmt", 16'(err_fmt_detailed), 16'(m.err_detailed));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(60982));
        rst_n = 1'b0;
        pd = 1'b0;
        cond = '0;
        contact_raw = 16'h0000;
        off_delay_running = 16'h0000;
        m = '0;
        m.status_sel = {5'h1c, 5'h1c, 5'h1c, 5'h1b, 5'h14, 5'h13, 5'h11};
        for (int i = 0; i < 16; i++) m.input_sel[i] = 5'(i);
        m.err_detailed = 1'b1;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        c = '0;
        c.startup_in = 1'b1;
        c.prepurge_running = 1'b1;
        step(c);
        c.prepurge_running = 1'b0;
        step(c);
        c.startup_in = 1'b0;
        step(c);
        repeat (8) step(slpm_cond_s'(13'($urandom)));
        repeat (24) begin
            c2 = slpm_cfg_s'(133'({$urandom, $urandom, $urandom, $urandom,
                $urandom}));
            loader.send(c2);
            m = c2;
            repeat (4) step(slpm_cond_s'(13'($urandom)));
        end
        tally_and_finish();
    end
endmodule
